// [rtl/pctr_regbank.sv]
/*
 * pctr_regbank: partner capability, partner identity and slot 0
 * remote target registers behind an AXI4-Lite slave, plus the slot 0
 * i2c address remap.
 * assumes: control channel strobes and i2c requests come from logic
 * on sys_clk_i; the slot 0 alias register lives elsewhere.
 */
// Contract
// - caps lock set freezes partner capability fields
// - caps load from channel once link detected
// - bit 5 shows partner self-test request
// - bit 4 shows single or multi port partner
// - bits 3:0 hold partner port number
// - identity bits 7:1 load from back channel
// - identity lock bit keeps software written identity
// - slot 0 alias hits get target address
// - target register bit 0 reads zero
`timescale 1ns/10ps
module pctr_regbank #(
   parameter int unsigned        ADDR_W    = 8,
   parameter logic [6:0]         IDENT_RST = 7'h2A // value arbitrary
) (
   // clock and reset
   input  wire logic                         sys_clk_i,
   input  wire logic                         reset_i,
   // axi4-lite write address and data
   input  wire logic [ADDR_W-1:0]            s_axi_awaddr_i,
   input  wire logic                         s_axi_awvalid_i,
   output logic                              s_axi_awready_o,
   input  wire logic [31:0]                  s_axi_wdata_i,
   input  wire logic [3:0]                   s_axi_wstrb_i,
   input  wire logic                         s_axi_wvalid_i,
   output logic                              s_axi_wready_o,
   // axi4-lite write response
   output logic [1:0]                        s_axi_bresp_o,
   output logic                              s_axi_bvalid_o,
   input  wire logic                         s_axi_bready_i,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0]            s_axi_araddr_i,
   input  wire logic                         s_axi_arvalid_i,
   output logic                              s_axi_arready_o,
   output logic [31:0]                       s_axi_rdata_o,
   output logic [1:0]                        s_axi_rresp_o,
   output logic                              s_axi_rvalid_o,
   input  wire logic                         s_axi_rready_i,
   // control channel reports
   input  wire logic                         bc_link_detected_i,
   input  wire logic                         bc_caps_valid_i,
   input  wire pctr_pkg::pctr_caps_type      bc_caps_i,
   input  wire logic                         bc_ident_valid_i,
   input  wire logic [6:0]                   bc_ident_i,
   // i2c remap
   input  wire pctr_pkg::pctr_remap_req_type remap_req_i,
   output pctr_pkg::pctr_remap_rsp_type      remap_rsp_o,
   // register contents for the rest of the device
   output logic [7:0]                        partner_caps_o,
   output logic [6:0]                        partner_ident_o
);
   import pctr_pkg::*;

   // register word index of a byte address
   function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] w;
      w = a >> 2;
      word_idx = w[7:0];
   endfunction

   // whether an index names a register of this bank
   function automatic logic is_mapped(input logic [7:0] idx);
      is_mapped = (idx >= IDX_CAPS) && (idx <= IDX_TARGET0);
   endfunction

   // register storage
   logic [7:0] caps_q, caps_d;         // capability flags
   logic [6:0] ident_q, ident_d;       // partner identity
   logic       ident_lock_q, ident_lock_d; // identity freeze
   logic [7:0] rsvd_a_q;               // spare storage at 0x36
   logic [7:0] rsvd_b_q;               // spare storage at 0x38
   logic [6:0] target0_q;              // slot 0 remote target

   // bus state
   logic              aw_have_q;       // write address captured
   logic              w_have_q;        // write data captured
   logic [ADDR_W-1:0] awaddr_q;        // held write address
   logic [7:0]        wdata_q;         // held low data lane
   logic              wstrb0_q;        // held low lane strobe
   logic              bvalid_q;        // write response pending
   logic [1:0]        bresp_q;         // write response code
   logic              rvalid_q;        // read data pending
   logic [31:0]       rdata_q;         // read data
   logic [1:0]        rresp_q;         // read response code
   pctr_remap_rsp_type rsp_q;          // forwarded address

   // decoded strobes
   logic       wr_do;                  // write happens this cycle
   logic [7:0] wr_idx;                 // index of that write
   logic       wr_caps;                // write hits capability flags
   logic       wr_ident;               // write hits identity
   logic       ar_fire;                // read address taken
   logic [7:0] ar_idx;                 // index of that read
   logic [7:0] rd_byte;                // selected register value

   // handshakes, each channel stalls while a response is pending
   assign s_axi_awready_o = !aw_have_q && !bvalid_q;
   assign s_axi_wready_o  = !w_have_q && !bvalid_q;
   assign s_axi_arready_o = !rvalid_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rdata_o   = rdata_q;
   assign s_axi_rresp_o   = rresp_q;
   assign remap_rsp_o     = rsp_q;
   assign partner_caps_o  = caps_q;
   assign partner_ident_o = ident_q;

   assign wr_do    = aw_have_q && w_have_q && !bvalid_q;
   assign wr_idx   = word_idx(awaddr_q);
   assign wr_caps  = wr_do && wstrb0_q && (wr_idx == IDX_CAPS);
   assign wr_ident = wr_do && wstrb0_q && (wr_idx == IDX_IDENT);
   assign ar_fire  = s_axi_arvalid_i && !rvalid_q;
   assign ar_idx   = word_idx(s_axi_araddr_i);

   // capture write address and data in either order
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= 8'h00;
         wstrb0_q  <= 1'b0;
      end else begin
         // address channel
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr_i;
         end else if (wr_do) begin
            aw_have_q <= 1'b0;
         end
         // data channel, only the low lane is stored
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata_i[7:0];
            wstrb0_q <= s_axi_wstrb_i[0];
         end else if (wr_do) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write response, decode error for unmapped words
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_q <= 1'b1;
         bresp_q  <= is_mapped(wr_idx) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready_i) begin
         bvalid_q <= 1'b0;
      end
   end

   // next capability value: software first, then the channel
   always_comb begin
      caps_d = caps_q;
      if (wr_caps) begin
         caps_d = wdata_q;
      end
      // channel load unless the new lock value freezes it
      if (bc_link_detected_i && bc_caps_valid_i
          && !caps_d[CAPS_LOCK_BIT]) begin
         caps_d[CAPS_SELF_BIT]       = bc_caps_i.selftest;
         caps_d[CAPS_MULTI_BIT]      = bc_caps_i.multi;
         caps_d[CAPS_PORT_MSB:0]     = bc_caps_i.port;
      end
   end

   // capability flags register
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         caps_q <= CAPS_RST;
      end else begin
         caps_q <= caps_d;
      end
   end

   // next identity value, same priority as the capabilities
   always_comb begin
      ident_d      = ident_q;
      ident_lock_d = ident_lock_q;
      if (wr_ident) begin
         ident_d      = wdata_q[7:ADDR_LSB];
         ident_lock_d = wdata_q[IDENT_LOCK_BIT];
      end
      // back channel identity unless frozen
      if (bc_ident_valid_i && !ident_lock_d) begin
         ident_d = bc_ident_i;
      end
   end

   // identity register
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         ident_q      <= IDENT_RST;
         ident_lock_q <= LOCK_RST;
      end else begin
         ident_q      <= ident_d;
         ident_lock_q <= ident_lock_d;
      end
   end

   // plain software registers
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rsvd_a_q  <= RSVD_RST;
         rsvd_b_q  <= RSVD_RST;
         target0_q <= TARGET_RST;
      end else if (wr_do && wstrb0_q) begin
         // bit 0 of the target word is dropped
         unique case (wr_idx)
            IDX_RSVD_A:  rsvd_a_q  <= wdata_q;
            IDX_RSVD_B:  rsvd_b_q  <= wdata_q;
            IDX_TARGET0: target0_q <= wdata_q[7:ADDR_LSB];
            default: ;
         endcase
      end
   end

   // read mux
   always_comb begin
      rd_byte = 8'h00;
      unique case (ar_idx)
         IDX_CAPS:    rd_byte = caps_q;
         IDX_RSVD_A:  rd_byte = rsvd_a_q;
         IDX_IDENT:   rd_byte = {ident_q, ident_lock_q};
         IDX_RSVD_B:  rd_byte = rsvd_b_q;
         IDX_TARGET0: rd_byte = {target0_q, 1'b0};
         default:     rd_byte = 8'h00;
      endcase
   end

   // read data channel, upper bits read zero
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_q <= 1'b1;
         rdata_q  <= {24'h000000, rd_byte};
         rresp_q  <= is_mapped(ar_idx) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   // slot 0 remap, alias supplied from outside
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         rsp_q <= '0;
      end else begin
         rsp_q.valid <= remap_req_i.valid;
         rsp_q.hit   <= remap_req_i.addr == remap_req_i.alias0;
         // matching address swapped for the target
         rsp_q.addr  <= (remap_req_i.addr == remap_req_i.alias0)
                        ? target0_q : remap_req_i.addr;
      end
   end

   // frozen fields hold while no software write
   lock_hold_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      caps_q[CAPS_LOCK_BIT] && !wr_caps |=> caps_q == $past(caps_q))
      else $error("caps changed while locked");

   // channel load lands next cycle
   caps_load_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      bc_link_detected_i && bc_caps_valid_i && !caps_q[CAPS_LOCK_BIT]
      && !wr_caps |=> caps_q[5:0] == $past(bc_caps_i))
      else $error("caps not loaded from channel");

   // no load without link
   no_link_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      !bc_link_detected_i && !wr_caps |=> $stable(caps_q))
      else $error("caps changed without link");

   // read shows self-test bit
   selftest_rd_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      ar_fire && ar_idx == IDX_CAPS
      |=> s_axi_rdata_o[5] == $past(caps_q[CAPS_SELF_BIT]))
      else $error("self-test bit read wrong");

   // read shows multi port bit
   multi_rd_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      ar_fire && ar_idx == IDX_CAPS
      |=> s_axi_rdata_o[4] == $past(caps_q[CAPS_MULTI_BIT]))
      else $error("multi port bit read wrong");

   // read shows port number
   port_rd_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      ar_fire && ar_idx == IDX_CAPS
      |=> s_axi_rdata_o[3:0] == $past(caps_q[3:0]))
      else $error("port number read wrong");

   // identity follows the back channel
   ident_load_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      bc_ident_valid_i && !ident_lock_q && !wr_ident
      |=> ident_q == $past(bc_ident_i))
      else $error("identity not loaded");

   // frozen identity holds
   ident_lock_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      ident_lock_q && !wr_ident |=> $stable(ident_q))
      else $error("identity changed while locked");

   // alias hit forwards the target
   remap_hit_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      remap_req_i.valid && remap_req_i.addr == remap_req_i.alias0
      |=> remap_rsp_o.hit && remap_rsp_o.addr == $past(target0_q))
      else $error("alias hit not remapped");

   // target bit 0 reads zero
   target_rsvd_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      ar_fire && ar_idx == IDX_TARGET0 |=> s_axi_rdata_o[0] == 1'b0)
      else $error("target bit 0 not zero");

   // miss passes address through
   remap_miss_a: assert property (
      @(posedge sys_clk_i) disable iff (reset_i)
      remap_req_i.valid && remap_req_i.addr != remap_req_i.alias0
      |=> !remap_rsp_o.hit && remap_rsp_o.addr == $past(remap_req_i.addr))
      else $error("miss altered address");

endmodule

// [include/pctr_pkg.sv]
/*
 * pctr_pkg: constants and carrier types for the partner capability
 * and remote target remap register bank.
 * assumes: byte address of a register is four times its index on an
 * AXI4-Lite bus with 32-bit data; eight bits sit in the low lane.
 */
package pctr_pkg;

   // register indices, byte address is index * 4
   localparam logic [7:0] IDX_CAPS     = 8'h35;
   localparam logic [7:0] IDX_RSVD_A   = 8'h36;
   localparam logic [7:0] IDX_IDENT    = 8'h37;
   localparam logic [7:0] IDX_RSVD_B   = 8'h38;
   localparam logic [7:0] IDX_TARGET0  = 8'h39;

   // capability flag field positions
   localparam int unsigned CAPS_LOCK_BIT  = 7;
   localparam int unsigned CAPS_SELF_BIT  = 5;
   localparam int unsigned CAPS_MULTI_BIT = 4;
   localparam int unsigned CAPS_PORT_MSB  = 3;

   // identity and target field positions
   localparam int unsigned IDENT_LOCK_BIT = 0;
   localparam int unsigned ADDR_LSB       = 1;

   // reset values
   localparam logic [7:0] CAPS_RST    = 8'h00;
   localparam logic [7:0] RSVD_RST    = 8'h00;
   localparam logic [6:0] TARGET_RST  = 7'h00;
   localparam logic       LOCK_RST    = 1'b0;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // capability record carried by the control channel
   typedef struct packed {
      logic       selftest;
      logic       multi;
      logic [3:0] port;
   } pctr_caps_type;

   // incoming local i2c address with the slot 0 alias
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
      logic [6:0] alias0;
   } pctr_remap_req_type;

   // forwarded address after remap
   typedef struct packed {
      logic       valid;
      logic       hit;
      logic [6:0] addr;
   } pctr_remap_rsp_type;

endpackage

// [test/pctr_partner_model.sv]
/*
 * pctr_partner_model: behavioural remote deserializer that reports link
 * state, capabilities and identity over the control channel.
 * assumes: shares sys_clk_i with the bank; the bench calls its tasks.
 */
`timescale 1ns/10ps
module pctr_partner_model (
   // clock
   input  wire logic               sys_clk_i,
   // control channel reports
   output logic                    bc_link_detected_o,
   output logic                    bc_caps_valid_o,
   output pctr_pkg::pctr_caps_type bc_caps_o,
   output logic                    bc_ident_valid_o,
   output logic [6:0]              bc_ident_o
);
   import pctr_pkg::*;

   // quiet channel, link down
   initial begin
      bc_link_detected_o = 1'b0;
      bc_caps_valid_o    = 1'b0;
      bc_caps_o          = 6'h2A;
      bc_ident_valid_o   = 1'b0;
      bc_ident_o         = 7'h55;
   end

   // link comes up or drops
   task automatic set_link(input logic up);
      @(posedge sys_clk_i);
      bc_link_detected_o <= up;
   endtask

   // one capability report, after slow idle cycles
   task automatic send_caps(input pctr_caps_type c, input int slow);
      repeat (slow) @(posedge sys_clk_i);
      @(posedge sys_clk_i);
      bc_caps_valid_o <= 1'b1;
      bc_caps_o       <= c;
      @(posedge sys_clk_i);
      bc_caps_valid_o <= 1'b0;
      bc_caps_o       <= ~c; // no stale value between reports
   endtask

   // one identity report
   task automatic send_ident(input logic [6:0] id);
      @(posedge sys_clk_i);
      bc_ident_valid_o <= 1'b1;
      bc_ident_o       <= id;
      @(posedge sys_clk_i);
      bc_ident_valid_o <= 1'b0;
      bc_ident_o       <= ~id; // no stale value between reports
   endtask
endmodule

// [test/partner_caps_target_remap_test.sv]
/*
 * partner_caps_target_remap_test: self-checking bench for pctr_regbank
 * with a reference register model and the partner model.
 * assumes: pctr_pkg compiled first; one clock, synchronous reset.
 */
`timescale 1ns/10ps
module partner_caps_target_remap_test;
   import pctr_pkg::*;
   localparam logic [6:0] ID_RST = 7'h15; // value arbitrary
   logic          sys_clk_i = 1'b0;
   logic          reset_i = 1'b1;
   logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
   logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic          arvalid = 1'b0, rready = 1'b0;
   logic [31:0]   wdata = 32'h0, rdata, d;
   logic [3:0]    wstrb = 4'h0;
   logic          awready, wready, bvalid, arready, rvalid;
   logic [1:0]    bresp, rresp, r;
   logic          link, cvld, ivld;
   pctr_caps_type caps;
   logic [6:0]    ident, pident, ea;
   logic [7:0]    pcaps, v;
   pctr_remap_req_type req = '0;
   pctr_remap_rsp_type rsp;
   logic [7:0]    ref_r [53:57]; // reference register file
   int            errors = 0, n_checks = 0, i;
   integer        seed = 32'haa723503;

   // free running clock
   always #5 sys_clk_i = ~sys_clk_i;

   pctr_regbank #(.IDENT_RST(ID_RST)) uut (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .bc_link_detected_i(link),
      .bc_caps_valid_i(cvld), .bc_caps_i(caps),
      .bc_ident_valid_i(ivld), .bc_ident_i(ident),
      .remap_req_i(req), .remap_rsp_o(rsp),
      .partner_caps_o(pcaps), .partner_ident_o(pident));

   pctr_partner_model pm (
      .sys_clk_i(sys_clk_i), .bc_link_detected_o(link),
      .bc_caps_valid_o(cvld), .bc_caps_o(caps),
      .bc_ident_valid_o(ivld), .bc_ident_o(ident));

   // compare and count
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // verdict and end of run
   task final_report;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // bounded wait ran out
   task automatic hung;
      errors++;
      $display("CHECK FAILED handshake expected answer seen timeout");
      final_report();
   endtask

   // axi write, address and data offered together
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] dt,
                         input logic [3:0] s, output logic [1:0] rs);
      int k;
      logic ta, tw, dn;
      dn = 1'b0;
      @(posedge sys_clk_i);
      {awaddr, wdata, wstrb} <= {a, dt, s};
      {awvalid, wvalid, bready} <= 3'b111;
      for (k = 0; k < 50 && !dn; k++) begin
         @(negedge sys_clk_i);
         ta = awvalid & awready;
         tw = wvalid & wready;
         dn = bvalid;
         rs = bresp;
         @(posedge sys_clk_i);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (dn) bready <= 1'b0;
      end
      if (!dn) hung();
   endtask

   // axi read
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] dt,
                         output logic [1:0] rs);
      int k;
      logic ta, dn;
      dn = 1'b0;
      @(posedge sys_clk_i);
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      for (k = 0; k < 50 && !dn; k++) begin
         @(negedge sys_clk_i);
         ta = arvalid & arready;
         dn = rvalid;
         dt = rdata;
         rs = rresp;
         @(posedge sys_clk_i);
         if (ta) arvalid <= 1'b0;
         if (dn) rready <= 1'b0;
      end
      if (!dn) hung();
   endtask

   // register outputs against the model
   task automatic outs;
      chk("partner_caps_o", {24'h0, ref_r[IDX_CAPS]}, {24'h0, pcaps});
      chk("partner_ident_o", {25'h0, ref_r[IDX_IDENT][7:1]}, {25'h0, pident});
   endtask

   // mapped write, model follows
   task automatic wr(input logic [7:0] idx, input logic [7:0] val);
      axi_wr({idx[5:0], 2'b00}, {24'h0, val}, 4'h1, r);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
      ref_r[idx] = (idx == IDX_TARGET0) ? (val & 8'hFE) : val;
   endtask

   // mapped read against the model
   task automatic rd_chk(input logic [7:0] idx);
      axi_rd({idx[5:0], 2'b00}, d, r);
      chk("rdata", {24'h0, ref_r[idx]}, d);
      chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
      outs();
   endtask

   // capability report, loads only with link up and lock clear
   task automatic ch_caps(input pctr_caps_type c, input int slow);
      pm.send_caps(c, slow);
      if (link && !ref_r[IDX_CAPS][7]) ref_r[IDX_CAPS][5:0] = c;
      @(negedge sys_clk_i);
      outs();
   endtask

   // identity report, loads unless identity lock set
   task automatic ch_ident(input logic [6:0] id);
      pm.send_ident(id);
      if (!ref_r[IDX_IDENT][0]) ref_r[IDX_IDENT][7:1] = id;
      @(negedge sys_clk_i);
      outs();
   endtask

   // main sequence
   initial begin
      ref_r = '{8'h00, 8'h00, {ID_RST, 1'b0}, 8'h00, 8'h00};
      repeat (12) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      for (i = 53; i <= 57; i++) rd_chk(i[7:0]);
      axi_rd(8'h10, d, r);
      chk("unmapped rdata", 32'h0, d);
      chk("unmapped rresp", {30'h0, RESP_DECERR}, {30'h0, r});
      axi_wr(8'h10, 32'hFFFFFFFF, 4'hF, r);
      chk("unmapped bresp", {30'h0, RESP_DECERR}, {30'h0, r});
      axi_wr({IDX_CAPS[5:0], 2'b00}, 32'h000000FF, 4'h0, r);
      chk("masked bresp", {30'h0, RESP_OKAY}, {30'h0, r});
      rd_chk(IDX_CAPS);
      v = $random(seed);
      wr(IDX_RSVD_A, v);
      wr(IDX_RSVD_B, ~v);
      rd_chk(IDX_RSVD_A);
      rd_chk(IDX_RSVD_B);
      ch_caps(6'h3F, 0);
      pm.set_link(1'b1);
      for (i = 0; i < 6; i++) begin
         v = $random(seed);
         ch_caps({i[0], i[1], v[3:0]}, i % 3);
         rd_chk(IDX_CAPS);
      end
      wr(IDX_CAPS, 8'hA9);
      ch_caps(6'h16, 1);
      rd_chk(IDX_CAPS);
      wr(IDX_CAPS, 8'h40);
      ch_caps(6'h2B, 0);
      for (i = 0; i < 3; i++) begin
         v = $random(seed);
         ch_ident(v[6:0]);
         rd_chk(IDX_IDENT);
      end
      wr(IDX_IDENT, 8'h23);
      ch_ident(7'h6E);
      rd_chk(IDX_IDENT);
      wr(IDX_IDENT, 8'h22);
      ch_ident(7'h4C);
      rd_chk(IDX_IDENT);
      wr(IDX_TARGET0, 8'hFF);
      rd_chk(IDX_TARGET0);
      v = $random(seed);
      wr(IDX_TARGET0, v);
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         d = $random(seed);
         ea = i[0] ? v[6:0] : d[6:0];
         @(posedge sys_clk_i);
         req <= {1'b1, ea, v[6:0]};
         @(posedge sys_clk_i);
         @(negedge sys_clk_i);
         chk("remap_rsp_o", {23'h0, 1'b1, ea == v[6:0],
             (ea == v[6:0]) ? ref_r[IDX_TARGET0][7:1] : ea}, {23'h0, rsp});
      end
      // second reset in mid-run, every register back to its reset value
      @(posedge sys_clk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      ref_r = '{8'h00, 8'h00, {ID_RST, 1'b0}, 8'h00, 8'h00};
      for (i = 53; i <= 57; i++) rd_chk(i[7:0]);
      final_report();
   end
endmodule
